// *** src/sep_map.vh ***
// constants of the serial eeprom slave front end
`ifndef SEP_MAP_VH
`define SEP_MAP_VH
// ****************************************
// memory geometry
// ****************************************
`define SEP_ADDR_W 11
`define SEP_LO_W 4
`define SEP_PAGE_W 7
`define SEP_PAGE_BYTES 16
// ****************************************
// command byte fields
// ****************************************
`define SEP_CMD_CODE_HI 7
`define SEP_CMD_CODE_LO 4
`define SEP_CMD_UPPER_HI 3
`define SEP_CMD_UPPER_LO 1
`define SEP_CMD_DIR_BIT 0
// ****************************************
// bit slots within a byte
// ****************************************
`define SEP_LAST_DATA_BIT 4'h7
`define SEP_ACK_SLOT 4'h8
// ****************************************
// buffering and reset values
// ****************************************
`define SEP_FIFO_W 12
`define SEP_FIFO_D 8
`define SEP_ERASED 8'hff
`define SEP_RST_BYTE 8'h00
// ****************************************
// timing
// ****************************************
`define SEP_CLK_NS 4
`define SEP_PROG_MAX_NS 8000000
`define SEP_PROG_OVERHEAD 40
`endif

// *** src/sep_sync.v ***
// two flop synchroniser, one per bit
`timescale 1ns/1ns
module sep_sync #(
   parameter W = 3
) (
   input wire clk,
   input wire rst_b,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;
   genvar i;
   // ****************************************
   // per bit stages
   // ****************************************
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_reg[i] <= 1'b1;
               sync_reg[i] <= 1'b1;
            end else begin
               meta_reg[i] <= d[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate
   assign q = sync_reg;
endmodule

// *** src/sep_fifo.v ***
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module sep_fifo #(
   parameter W = 12,
   parameter D = 8,
   parameter AW = 3
) (
   input wire clk,
   input wire rst_b,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wr_reg;
   reg [AW-1:0] rd_reg;
   reg [AW:0] cnt_reg;
   wire push;
   wire pop;
   assign in_ready = (cnt_reg != D);
   assign out_valid = (cnt_reg != 0);
   assign out_data = mem[rd_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   // ****************************************
   // pointers and storage
   // ****************************************
   always @(posedge clk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == D - 1) ? {AW{1'b0}} : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == D - 1) ? {AW{1'b0}} : rd_reg + 1'b1;
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule

// *** src/sep_eeprom.v ***
// two-wire serial eeprom slave: bus engine, page buffer, timed programming
`timescale 1ns/1ns
`include "sep_map.vh"
module sep_eeprom #(
   parameter DEV_CODE = 4'h6, // arbitrary value
   parameter PROG_CYCLES = `SEP_PROG_MAX_NS / `SEP_CLK_NS
) (
   input wire clk,
   input wire rst_b,
   input wire scl_i,
   input wire sda_i,
   input wire wp_i,
   output reg sda_o,
   output reg sda_oe,
   output reg prog_busy
);
   localparam ST_IDLE = 3'd0;
   localparam ST_CMD = 3'd1;
   localparam ST_ADDR = 3'd2;
   localparam ST_WDATA = 3'd3;
   localparam ST_RDATA = 3'd4;
   localparam P_IDLE = 2'd0;
   localparam P_ERASE = 2'd1;
   localparam P_WAIT = 2'd2;
   localparam P_WRITE = 2'd3;
   localparam integer WAIT_INT = PROG_CYCLES - `SEP_PROG_OVERHEAD;
   localparam [23:0] WAIT_CYCLES = WAIT_INT[23:0];
   // ****************************************
   // storage
   // ****************************************
   reg [7:0] mem [0:(1<<`SEP_ADDR_W)-1];
   reg [7:0] pbuf [0:`SEP_PAGE_BYTES-1];
   // ****************************************
   // state
   // ****************************************
   reg scl_d_reg;
   reg sda_d_reg;
   reg [2:0] st_reg;
   reg [3:0] bit_reg;
   reg [7:0] sh_reg;
   reg [7:0] tx_reg;
   reg ack_ok_reg;
   reg [`SEP_ADDR_W-1:0] addr_reg;
   reg [2:0] upper_reg;
   reg [`SEP_PAGE_BYTES-1:0] mask_reg;
   reg [`SEP_LO_W-1:0] last_lo_reg;
   reg prog_req_reg;
   reg [1:0] pst_reg;
   reg [3:0] idx_reg;
   reg [23:0] tmr_reg;
   wire [2:0] pin_s;
   wire scl_s;
   wire sda_s;
   wire wp_s;
   wire scl_rise;
   wire scl_fall;
   wire start_c;
   wire stop_c;
   wire [7:0] byte_in;
   wire busy;
   wire fifo_in_ready;
   wire fifo_in_valid;
   wire fifo_out_valid;
   wire fifo_out_ready;
   wire [`SEP_FIFO_W-1:0] fifo_out_data;
   wire [`SEP_ADDR_W-1:0] prog_addr;
   reg [`SEP_PAGE_BYTES-1:0] pmask_reg;
   wire cmd_match;
   wire cmd_read;
   wire [2:0] cmd_upper;
   wire last_bit;
   wire ack_slot;
   wire master_ack;
   wire data_take;
   wire prog_start;
   wire prog_end;
   wire idx_last;
   wire tmr_zero;
   wire buf_take;
   // ****************************************
   // pin synchronisers and bus events
   // ****************************************
   // stages reset to the idle bus level so no false edge or start follows reset
   sep_sync #(.W(3)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d({wp_i, sda_i, scl_i}),
      .q(pin_s)
   );
   assign scl_s = pin_s[0];
   assign sda_s = pin_s[1];
   assign wp_s = pin_s[2];
   assign scl_rise = scl_s && !scl_d_reg;
   assign scl_fall = !scl_s && scl_d_reg;
   assign start_c = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   assign stop_c = scl_s && scl_d_reg && !sda_d_reg && sda_s;
   assign byte_in = {sh_reg[6:0], sda_s};
   assign busy = prog_req_reg || (pst_reg != P_IDLE);
   // ****************************************
   // byte decode and transfer qualifiers
   // ****************************************
   // decoded from the assembled byte so the verdict lands on the eighth rise itself
   assign cmd_match = (byte_in[`SEP_CMD_CODE_HI:`SEP_CMD_CODE_LO] == DEV_CODE);
   assign cmd_read = byte_in[`SEP_CMD_DIR_BIT];
   assign cmd_upper = byte_in[`SEP_CMD_UPPER_HI:`SEP_CMD_UPPER_LO];
   assign last_bit = (bit_reg == `SEP_LAST_DATA_BIT);
   assign ack_slot = (bit_reg == `SEP_ACK_SLOT);
   assign master_ack = scl_rise && ack_slot && (st_reg == ST_RDATA) && !sda_s;
   assign data_take = scl_rise && last_bit && (st_reg == ST_WDATA) && fifo_in_ready;
   // the live mask is wiped by the stop itself, so programming works from a copy
   assign prog_start = stop_c && (st_reg == ST_WDATA) && (mask_reg != {`SEP_PAGE_BYTES{1'b0}}) && !wp_s;
   assign idx_last = (idx_reg == 4'hf);
   assign prog_end = (pst_reg == P_WRITE) && idx_last;
   assign tmr_zero = (tmr_reg == 24'h00_0000);
   assign buf_take = fifo_out_valid && fifo_out_ready;
   // ****************************************
   // page buffer feed
   // ****************************************
   // a full fifo withholds the data acknowledge so no byte is lost
   assign fifo_in_valid = scl_rise && (st_reg == ST_WDATA) && last_bit;
   assign fifo_out_ready = (pst_reg == P_IDLE);
   sep_fifo #(.W(`SEP_FIFO_W), .D(`SEP_FIFO_D), .AW(3)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data({addr_reg[`SEP_LO_W-1:0], byte_in}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );
   always @(posedge clk) begin
      if (buf_take) begin
         pbuf[fifo_out_data[11:8]] <= fifo_out_data[7:0];
      end
   end
   // ****************************************
   // bus engine
   // ****************************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         st_reg <= ST_IDLE;
         bit_reg <= 4'h0;
         sh_reg <= `SEP_RST_BYTE;
         tx_reg <= `SEP_RST_BYTE;
         ack_ok_reg <= 1'b0;
         upper_reg <= 3'h0;
         mask_reg <= {`SEP_PAGE_BYTES{1'b0}};
         last_lo_reg <= 4'h0;
         sda_o <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
         sda_o <= 1'b0;
         if (start_c) begin
            // a repeated start drops any pending page entry
            st_reg <= ST_CMD;
            mask_reg <= {`SEP_PAGE_BYTES{1'b0}};
            bit_reg <= 4'h0;
            ack_ok_reg <= 1'b0;
            sda_oe <= 1'b0;
         end else if (stop_c) begin
            st_reg <= ST_IDLE;
            sda_oe <= 1'b0;
            mask_reg <= {`SEP_PAGE_BYTES{1'b0}};
         end else if (st_reg == ST_IDLE) begin
            sda_oe <= 1'b0;
         end else if (scl_rise) begin
            if (!ack_slot) begin
               sh_reg <= byte_in;
               bit_reg <= bit_reg + 4'h1;
            end else begin
               bit_reg <= 4'h0;
            end
            if (last_bit) begin
               ack_ok_reg <= 1'b0;
               case (st_reg)
                  ST_CMD: begin
                     if (!cmd_match) begin
                        st_reg <= ST_IDLE;
                     end else if (busy) begin
                        st_reg <= ST_IDLE;
                     end else if (!cmd_read) begin
                        upper_reg <= cmd_upper;
                        ack_ok_reg <= 1'b1;
                        st_reg <= ST_ADDR;
                     end else begin
                        ack_ok_reg <= 1'b1;
                        st_reg <= ST_RDATA;
                     end
                  end
                  ST_ADDR: begin
                     ack_ok_reg <= 1'b1;
                     st_reg <= ST_WDATA;
                  end
                  ST_WDATA: begin
                     if (fifo_in_ready) begin
                        ack_ok_reg <= 1'b1;
                        mask_reg[addr_reg[`SEP_LO_W-1:0]] <= 1'b1;
                        last_lo_reg <= addr_reg[`SEP_LO_W-1:0];
                     end
                  end
                  default: begin
                     ack_ok_reg <= 1'b0;
                  end
               endcase
            end
            if (ack_slot && st_reg == ST_RDATA) begin
               if (!sda_s) begin
                  tx_reg <= mem[addr_reg];
               end else begin
                  st_reg <= ST_IDLE;
               end
            end
         end else if (scl_fall) begin
            if (ack_slot) begin
               sda_oe <= ack_ok_reg;
            end else if (st_reg == ST_RDATA) begin
               sda_oe <= !tx_reg[7];
               tx_reg <= {tx_reg[6:0], 1'b1};
            end else begin
               sda_oe <= 1'b0;
            end
         end
      end
   end
   // ****************************************
   // address counter
   // ****************************************
   // the end of programming takes priority; bus commands are refused while it runs
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_reg <= {`SEP_ADDR_W{1'b0}};
      end else if (prog_end) begin
         addr_reg <= {addr_reg[`SEP_ADDR_W-1:`SEP_LO_W], last_lo_reg};
      end else if (scl_rise && !start_c && !stop_c) begin
         if (st_reg == ST_ADDR && last_bit) begin
            addr_reg <= {upper_reg, byte_in};
         end else if (data_take) begin
            addr_reg[`SEP_LO_W-1:0] <= addr_reg[`SEP_LO_W-1:0] + 4'h1;
         end else if (master_ack) begin
            addr_reg <= addr_reg + 1'b1;
         end
      end
   end
   // ****************************************
   // programming mask copy
   // ****************************************
   // a polling start must not wipe the bytes chosen for the running cycle
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pmask_reg <= {`SEP_PAGE_BYTES{1'b0}};
      end else if (prog_start) begin
         pmask_reg <= mask_reg;
      end else if (prog_end) begin
         pmask_reg <= {`SEP_PAGE_BYTES{1'b0}};
      end
   end
   // ****************************************
   // programming sequencer
   // ****************************************
   // erase and write walk the page one byte per cycle; the wait soaks up the rest
   assign prog_addr = {addr_reg[`SEP_ADDR_W-1:`SEP_LO_W], idx_reg};
   always @(posedge clk) begin
      if (pst_reg == P_ERASE && pmask_reg[idx_reg]) begin
         mem[prog_addr] <= `SEP_ERASED;
      end else if (pst_reg == P_WRITE && pmask_reg[idx_reg]) begin
         mem[prog_addr] <= pbuf[idx_reg];
      end
   end
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prog_req_reg <= 1'b0;
         pst_reg <= P_IDLE;
         idx_reg <= 4'h0;
         tmr_reg <= 24'h00_0000;
         prog_busy <= 1'b0;
      end else begin
         prog_busy <= busy;
         if (prog_start) begin
            prog_req_reg <= 1'b1;
         end
         case (pst_reg)
            P_IDLE: begin
               // wait until the last byte has left the fifo for the page buffer
               if (prog_req_reg && !fifo_out_valid) begin
                  prog_req_reg <= 1'b0;
                  pst_reg <= P_ERASE;
                  idx_reg <= 4'h0;
               end
            end
            P_ERASE: begin
               idx_reg <= idx_reg + 4'h1;
               if (idx_last) begin
                  pst_reg <= P_WAIT;
                  tmr_reg <= WAIT_CYCLES;
               end
            end
            P_WAIT: begin
               if (tmr_zero) begin
                  pst_reg <= P_WRITE;
                  idx_reg <= 4'h0;
               end else begin
                  tmr_reg <= tmr_reg - 24'h00_0001;
               end
            end
            P_WRITE: begin
               idx_reg <= idx_reg + 4'h1;
               if (idx_last) begin
                  pst_reg <= P_IDLE;
               end
            end
            default: begin
               pst_reg <= P_IDLE;
            end
         endcase
      end
   end
endmodule

// *** dv/sep_eeprom_assertions.sv ***
// pin-level assertions for the serial eeprom slave
`timescale 1ns/1ns
module sep_eeprom_assertions #(
   parameter PROG_CYCLES = 200
) (
   input wire clk,
   input wire rst_b,
   input wire scl_i,
   input wire sda_i,
   input wire wp_i,
   input wire sda_o,
   input wire sda_oe,
   input wire prog_busy
);
   reg scl_q;
   reg sda_q;
   reg [7:0] fall_age;
   reg [7:0] stop_age;
   reg [31:0] busy_cnt;
   // ****************************************
   // helper ages, saturating so idle time never wraps to zero
   // ****************************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         fall_age <= 8'hff;
         stop_age <= 8'hff;
         busy_cnt <= 32'h0000_0000;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
         busy_cnt <= prog_busy ? busy_cnt + 32'h0000_0001 : 32'h0000_0000;
         if (scl_q && !scl_i)
            fall_age <= 8'h00;
         else if (fall_age != 8'hff)
            fall_age <= fall_age + 8'h01;
         if (scl_q && scl_i && !sda_q && sda_i)
            stop_age <= 8'h00;
         else if (stop_age != 8'hff)
            stop_age <= stop_age + 8'h01;
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence stop_seen;
      stop_age == 8'h00;
   endsequence
   sequence line_released;
      !sda_oe [*8];
   endsequence
   chk_drive_low: assert property (sda_oe |-> !sda_o)
      else $error("data line driven high");
   chk_oe_rise_time: assert property ($rose(sda_oe) |-> fall_age <= 8'h06)
      else $error("drive starts away from clock fall");
   chk_oe_fall_time: assert property ($fell(sda_oe) |-> fall_age <= 8'h06)
      else $error("release away from clock fall");
   // the line must not move while the master samples it
   chk_oe_stable_high: assert property (scl_i && $past(scl_i) && $past(scl_i, 2)
      |-> $stable(sda_oe))
      else $error("data changed during clock high");
   chk_busy_refuse: assert property (prog_busy |-> !sda_oe)
      else $error("drive while programming");
   chk_busy_bound: assert property (prog_busy |-> busy_cnt < PROG_CYCLES)
      else $error("programming too long");
   chk_busy_cause: assert property ($rose(prog_busy) |-> stop_age <= 8'h0c)
      else $error("programming without stop");
   chk_release_stop: assert property (stop_seen |-> line_released)
      else $error("line held after stop");
   chk_protect_hold: assert property (wp_i && $past(wp_i, 8) |-> !$rose(prog_busy))
      else $error("programming while protected");
endmodule
bind sep_eeprom sep_eeprom_assertions #(.PROG_CYCLES(PROG_CYCLES)) i_sep_eeprom_assertions (
   .clk(clk),
   .rst_b(rst_b),
   .scl_i(scl_i),
   .sda_i(sda_i),
   .wp_i(wp_i),
   .sda_o(sda_o),
   .sda_oe(sda_oe),
   .prog_busy(prog_busy)
);

// *** dv/sep_master.sv ***
// two-wire bus master model: drives clock, pulls data low
`timescale 1ns/1ns
module sep_master (
   input wire clk,
   input wire sda,
   output reg scl,
   output reg sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task tick(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // works from idle and as a repeated start
   task start;
      begin
         sda_low <= 1'b0;
         tick(3);
         scl <= 1'b1;
         tick(6);
         sda_low <= 1'b1;
         tick(6);
         scl <= 1'b0;
         tick(3);
      end
   endtask
   task stop;
      begin
         sda_low <= 1'b1;
         tick(3);
         scl <= 1'b1;
         tick(6);
         sda_low <= 1'b0;
         tick(6);
      end
   endtask
   // 12 clk per bit; data moves only in the low phase
   task bit_io(input logic b, output logic r);
      begin
         sda_low <= ~b;
         tick(3);
         scl <= 1'b1;
         tick(3);
         r = sda;
         tick(3);
         scl <= 1'b0;
         tick(3);
      end
   endtask
   task wr_byte(input logic [7:0] d, output logic ack);
      integer i;
      logic r;
      begin
         for (i = 7; i >= 0; i = i - 1)
            bit_io(d[i], r);
         bit_io(1'b1, r);
         ack = ~r;
      end
   endtask
   task rd_byte(input logic more, output logic [7:0] d);
      integer i;
      logic r;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bit_io(1'b1, r);
            d[i] = r;
         end
         bit_io(~more, r);
      end
   endtask
endmodule

// *** dv/sep_eeprom_tb_top.sv ***
// self-checking bench for the serial eeprom slave
`timescale 1ns/1ns
module sep_eeprom_tb_top;
   // short programming count keeps the run brief
   localparam int PROG = 200;
   localparam logic [3:0] CODE = 4'h6; // arbitrary type code
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic wp = 1'b0;
   logic [7:0] mem [0:2047];
   logic [10:0] ptr = 11'h000;
   integer err_count = 0;
   integer checks = 0;
   wire scl;
   wire sda_low;
   wire sda_o;
   wire sda_oe;
   wire busy;
   // pull-up: the line is low only while someone pulls it
   wire sda = ~(sda_low | (sda_oe & ~sda_o));
   always #2 clk = ~clk;
   sep_eeprom #(.DEV_CODE(CODE), .PROG_CYCLES(PROG)) i_sep_eeprom (
      .clk(clk),
      .rst_b(rst_b),
      .scl_i(scl),
      .sda_i(sda),
      .wp_i(wp),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .prog_busy(busy)
   );
   sep_master i_sep_master (
      .clk(clk),
      .sda(sda),
      .scl(scl),
      .sda_low(sda_low)
   );
   // ****************************************
   // compare and closing tasks
   // ****************************************
   task cmp_bit(input logic exp, input logic got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0t bit exp %b got %b", $time, exp, got);
         end
      end
   endtask
   task cmp_byte(input logic [7:0] exp, input logic [7:0] got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0t byte exp %h got %h", $time, exp, got);
         end
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d errors %0d", checks, err_count);
         if (err_count == 0 && checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // ****************************************
   // bus helpers
   // ****************************************
   task send_cmd(input logic [10:0] a, input logic rd, input logic exp_ack);
      logic ack;
      begin
         i_sep_master.start;
         i_sep_master.wr_byte({CODE, a[10:8], rd}, ack);
         cmp_bit(exp_ack, ack);
      end
   endtask
   task set_addr(input logic [10:0] a);
      logic ack;
      begin
         send_cmd(a, 1'b0, 1'b1);
         i_sep_master.wr_byte(a[7:0], ack);
         cmp_bit(1'b1, ack);
      end
   endtask
   task write_page(input logic [10:0] a, input integer n, input logic [7:0] base);
      integer i;
      logic ack;
      begin
         set_addr(a);
         for (i = 0; i < n; i = i + 1) begin
            i_sep_master.wr_byte(base + i[7:0], ack);
            cmp_bit(1'b1, ack);
            if (wp == 1'b0)
               mem[{a[10:4], a[3:0] + i[3:0]}] = base + i[7:0];
         end
         ptr = {a[10:4], a[3:0] + i[3:0] - 4'h1};
         i_sep_master.stop;
      end
   endtask
   task wait_done;
      integer n;
      begin
         cmp_bit(1'b1, busy);
         n = 0;
         while (busy !== 1'b0 && n < PROG) begin
            @(posedge clk);
            n = n + 1;
         end
         cmp_bit(1'b0, busy);
         if (busy !== 1'b0)
            stop_test;
      end
   endtask
   task read_run(input integer n);
      integer i;
      logic [7:0] d;
      begin
         for (i = 0; i < n; i = i + 1) begin
            i_sep_master.rd_byte(i < n - 1, d);
            cmp_byte(mem[ptr], d);
            ptr = ptr + 11'h001;
         end
         i_sep_master.stop;
      end
   endtask
   task rand_read(input logic [10:0] a, input integer n);
      begin
         set_addr(a);
         ptr = a;
         send_cmd(11'h700, 1'b1, 1'b1);
         read_run(n);
         cmp_bit(1'b0, busy);
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_page_poll;
      begin
         write_page(11'h7f0, 16, 8'h10);
         send_cmd(11'h000, 1'b0, 1'b0);
         i_sep_master.stop;
         wait_done;
         send_cmd(11'h000, 1'b1, 1'b1);
         read_run(1);
      end
   endtask
   task t_wrap_page;
      begin
         write_page(11'h000, 1, 8'h5a);
         wait_done;
         write_page(11'h7fe, 4, 8'ha0);
         wait_done;
         send_cmd(11'h000, 1'b1, 1'b1);
         read_run(1);
         rand_read(11'h7f0, 17);
      end
   endtask
   task t_wrong_code;
      logic ack;
      begin
         i_sep_master.start;
         i_sep_master.wr_byte({CODE ^ 4'h3, 4'h0}, ack);
         cmp_bit(1'b0, ack);
         i_sep_master.wr_byte(8'h00, ack);
         cmp_bit(1'b0, ack);
         i_sep_master.stop;
      end
   endtask
   task t_protect;
      begin
         wp <= 1'b1;
         write_page(11'h000, 1, 8'hc3);
         cmp_bit(1'b0, busy);
         wp <= 1'b0;
         rand_read(11'h000, 1);
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      t_page_poll;
      t_wrap_page;
      t_wrong_code;
      t_protect;
      stop_test;
   end
endmodule
